//--- dtc_pin_model.sv
`timescale 1ns/1ps
// Board side of the pins: one count source and two interrupt lines
module dtc_pin_model (
  // Clock
  input  wire logic clk,
  // Driven pins
  output logic      count_pin,
  output logic      irq_a,
  output logic      irq_b
);
  // Idle high, as pulled-up lines sit
  initial begin
    count_pin = 1'b1;
    irq_a     = 1'b1;
    irq_b     = 1'b1;
  end

  // Each level held several clocks so the sampler cannot miss it
  task automatic falls(input int n);
    repeat (n) begin
      @(posedge clk);
      count_pin <= 1'b0;
      repeat (3) @(posedge clk);
      count_pin <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask

  // Level change on one interrupt line
  task automatic set_irq(input int i, input logic v);
    @(posedge clk);
    if (i == 0) begin
      irq_a <= v;
    end else begin
      irq_b <= v;
    end
  endtask
endmodule

//--- dtc_pin_sync.sv
`timescale 1ns/1ps
module dtc_pin_sync #(
  parameter int W = dtc_pkg::PIN_NUM
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Raw pins
  input  wire logic [W-1:0] pin_in,
  // Synchronised view
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] fall_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // Two stages per lane, then an edge stage reading only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[i] <= 1'b1;
          sync_reg[i] <= 1'b1;
          prev_reg[i] <= 1'b1;
        end else begin
          meta_reg[i] <= pin_in[i];
          sync_reg[i] <= meta_reg[i];
          prev_reg[i] <= sync_reg[i];
        end
      end
      assign level_out[i] = sync_reg[i];
      assign fall_out[i]  = prev_reg[i] & ~sync_reg[i];
    end
  endgenerate

endmodule

//--- dtc_pkg.sv
package dtc_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE    = 8'h89;
  localparam logic [7:0] ADDR_A_LOW   = 8'h8a;
  localparam logic [7:0] ADDR_B_LOW   = 8'h8b;
  localparam logic [7:0] ADDR_A_HIGH  = 8'h8c;
  localparam logic [7:0] ADDR_B_HIGH  = 8'h8d;

  // Control register bit positions
  localparam int CTL_B_OVF   = 7;
  localparam int CTL_B_RUN   = 6;
  localparam int CTL_A_OVF   = 5;
  localparam int CTL_A_RUN   = 4;
  localparam int CTL_XB_FLAG = 3;
  localparam int CTL_XB_TRIG = 2;
  localparam int CTL_XA_FLAG = 1;
  localparam int CTL_XA_TRIG = 0;

  // Mode register fields
  localparam int MOD_A_GATE = 3;
  localparam int MOD_A_SRC  = 2;
  localparam int MOD_A_MODE = 0;

  // Timer A mode codes
  localparam logic [1:0] MODE_PRESC  = 2'h0;
  localparam logic [1:0] MODE_WIDE   = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;

  // Pin synchroniser lanes
  localparam int PIN_COUNT_A = 0;
  localparam int PIN_IRQ_A   = 1;
  localparam int PIN_IRQ_B   = 2;
  localparam int PIN_NUM     = 3;

endpackage

//--- dtc_timer_ctrl.sv
`timescale 1ns/1ps
// Function
// (RULE1) Source bit picks count pin or clock
// (RULE2) Mode 00: high byte, 5-bit prescaler
// (RULE3) Mode 01: one cascaded 16-bit counter
// (RULE4) Mode 10: low byte reloads from high
// (RULE5) Mode 11: split bytes, high under B
// (RULE6) B overflow flag set, cleared on vector
// (RULE7) Timer B counts only while running
// (RULE8) A overflow flag set, cleared on vector
// (RULE9) Timer A counts only while running; in mode 11 the high byte counts under the timer B run bit instead
// (RULE10) Ext B flag: falling edge or low
// (RULE11) Vector clears edge flags; level follows pin
// (RULE12) Trigger bit 1 edge, 0 level
// (RULE13) Ext A behaves same at bits 1/0
// (RULE14) Ext bits never touch timer counting
// (RULE15) A gated by run and gate/pin
// (RULE16) Prescaled mode is 13-bit rollover counter
// (RULE17) Run bit never clears count registers
// (RULE18) Count pin falls counted once each
module dtc_timer_ctrl (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Vector acknowledges from the core
  input  wire logic       vec_timer_a,
  input  wire logic       vec_timer_b,
  input  wire logic       vec_ext_a,
  input  wire logic       vec_ext_b,
  // External pins
  input  wire logic       timer_a_count_pin,
  input  wire logic       ext_irq_a_pin,
  input  wire logic       ext_irq_b_pin,
  // Request flags
  output logic            timer_a_overflow_flag,
  output logic            timer_b_overflow_flag,
  output logic            ext_irq_a_flag,
  output logic            ext_irq_b_flag
);

  logic       rst_meta_reg;
  logic       rst_n;
  logic [7:0] reg_rdata_reg;
  logic [7:0] mode_reg;
  logic       run_a_reg;
  logic       run_b_reg;
  logic       trig_a_reg;
  logic       trig_b_reg;
  logic       timer_a_overflow_flag_reg;
  logic       timer_b_overflow_flag_reg;
  logic       ext_irq_a_flag_reg;
  logic       ext_irq_b_flag_reg;
  logic [7:0] timer_a_low_reg;
  logic [7:0] timer_a_high_reg;
  logic [7:0] timer_a_low_next;
  logic [7:0] timer_a_high_next;
  logic [15:0] timer_b_reg;
  logic [15:0] timer_b_next;
  logic [2:0] pin_level;
  logic [2:0] pin_fall;
  logic       wr_ctl;
  logic       wr_a_low;
  logic       wr_a_high;
  logic       count_a_en;
  logic       ovf_a;
  logic       ovf_split_high;
  logic       ovf_b;
  logic [1:0] timer_a_mode;

  // Reset released through two flops, asserted at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Pins reach the logic only after two flops
  dtc_pin_sync #(
    .W (dtc_pkg::PIN_NUM)
  ) u_pin_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_in    ({ext_irq_b_pin, ext_irq_a_pin, timer_a_count_pin}),
    .level_out (pin_level),
    .fall_out  (pin_fall)
  );

  assign wr_ctl       = reg_wr && (reg_addr == dtc_pkg::ADDR_CONTROL);
  assign wr_a_low     = reg_wr && (reg_addr == dtc_pkg::ADDR_A_LOW);
  assign wr_a_high    = reg_wr && (reg_addr == dtc_pkg::ADDR_A_HIGH);
  assign timer_a_mode = mode_reg[dtc_pkg::MOD_A_MODE +: 2];

  // Software-owned control bits; ext bits only reach the ext logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg   <= dtc_pkg::RST_BYTE;
      run_a_reg  <= 1'b0;
      run_b_reg  <= 1'b0;
      trig_a_reg <= 1'b0;
      trig_b_reg <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == dtc_pkg::ADDR_MODE)) begin
        mode_reg <= reg_wdata;
      end
      if (wr_ctl) begin
        run_a_reg  <= reg_wdata[dtc_pkg::CTL_A_RUN];
        run_b_reg  <= reg_wdata[dtc_pkg::CTL_B_RUN];
        trig_a_reg <= reg_wdata[dtc_pkg::CTL_XA_TRIG];
        trig_b_reg <= reg_wdata[dtc_pkg::CTL_XB_TRIG];
      end
    end
  end

  // Timer A count enable: run, gate, then clock or pin falls
  assign count_a_en = run_a_reg                                        // [RULE9] [RULE14]
                      && (!mode_reg[dtc_pkg::MOD_A_GATE] || pin_level[dtc_pkg::PIN_IRQ_A]) // [RULE15]
                      && (mode_reg[dtc_pkg::MOD_A_SRC] ? pin_fall[dtc_pkg::PIN_COUNT_A] : 1'b1); // [RULE1] [RULE18]

  // Timer A next value per mode; a software write wins over counting
  always_comb begin
    timer_a_low_next  = timer_a_low_reg;
    timer_a_high_next = timer_a_high_reg;
    ovf_a             = 1'b0;
    ovf_split_high    = 1'b0;
    if (count_a_en) begin
      case (timer_a_mode)
        dtc_pkg::MODE_PRESC: begin
          // Upper three low bits are left alone, so they hold what was written
          if (timer_a_low_reg[4:0] == 5'h1f) begin
            timer_a_low_next  = {timer_a_low_reg[7:5], 5'h00};             // [RULE2]
            timer_a_high_next = 8'(timer_a_high_reg + 8'h01);              // [RULE2]
            ovf_a             = (timer_a_high_reg == 8'hff);               // [RULE16]
          end else begin
            timer_a_low_next = {timer_a_low_reg[7:5], 5'(timer_a_low_reg[4:0] + 5'h01)};
          end
        end
        dtc_pkg::MODE_WIDE: begin
          timer_a_low_next = 8'(timer_a_low_reg + 8'h01);                  // [RULE3]
          if (timer_a_low_reg == 8'hff) begin
            timer_a_high_next = 8'(timer_a_high_reg + 8'h01);              // [RULE3]
            ovf_a             = (timer_a_high_reg == 8'hff);
          end
        end
        dtc_pkg::MODE_RELOAD: begin
          if (timer_a_low_reg == 8'hff) begin
            timer_a_low_next = timer_a_high_reg;                           // [RULE4]
            ovf_a            = 1'b1;
          end else begin
            timer_a_low_next = 8'(timer_a_low_reg + 8'h01);
          end
        end
        default: begin
          timer_a_low_next = 8'(timer_a_low_reg + 8'h01);                  // [RULE5]
          ovf_a            = (timer_a_low_reg == 8'hff);
        end
      endcase
    end
    // Split mode: high byte times the clock under timer B run bit
    if ((timer_a_mode == dtc_pkg::MODE_SPLIT) && run_b_reg) begin
      timer_a_high_next = 8'(timer_a_high_reg + 8'h01);                    // [RULE5]
      ovf_split_high    = (timer_a_high_reg == 8'hff);
    end
    if (wr_a_low) begin
      timer_a_low_next = reg_wdata;
    end
    if (wr_a_high) begin
      timer_a_high_next = reg_wdata;
    end
  end

  // Timer A count registers; run bit alone never clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_a_low_reg  <= dtc_pkg::RST_DATA;
      timer_a_high_reg <= dtc_pkg::RST_DATA;
    end else begin
      timer_a_low_reg  <= timer_a_low_next;                                // [RULE17]
      timer_a_high_reg <= timer_a_high_next;
    end
  end

  // Timer B: plain 16-bit clock timer while its run bit is set
  always_comb begin
    timer_b_next = timer_b_reg;
    ovf_b        = 1'b0;
    if (run_b_reg) begin
      timer_b_next = 16'(timer_b_reg + 16'h0001);                          // [RULE7]
      ovf_b        = (timer_b_reg == 16'hffff);
    end
    if (reg_wr && (reg_addr == dtc_pkg::ADDR_B_LOW)) begin
      timer_b_next[7:0] = reg_wdata;
    end
    if (reg_wr && (reg_addr == dtc_pkg::ADDR_B_HIGH)) begin
      timer_b_next[15:8] = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_b_reg <= {dtc_pkg::RST_DATA, dtc_pkg::RST_DATA};
    end else begin
      timer_b_reg <= timer_b_next;
    end
  end

  // Overflow flags: hardware set wins over vector or software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_a_overflow_flag_reg <= 1'b0;
      timer_b_overflow_flag_reg <= 1'b0;
    end else begin
      timer_a_overflow_flag_reg <= ovf_a
        || (wr_ctl ? reg_wdata[dtc_pkg::CTL_A_OVF] : (timer_a_overflow_flag_reg && !vec_timer_a)); // [RULE8]
      // Split mode lends this flag to the high byte of timer A
      timer_b_overflow_flag_reg <= ((timer_a_mode == dtc_pkg::MODE_SPLIT) ? ovf_split_high : ovf_b)
        || (wr_ctl ? reg_wdata[dtc_pkg::CTL_B_OVF] : (timer_b_overflow_flag_reg && !vec_timer_b)); // [RULE6]
    end
  end

  // External flags: edge mode latches falls, level mode tracks the pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_a_flag_reg <= 1'b0;
      ext_irq_b_flag_reg <= 1'b0;
    end else begin
      if (trig_a_reg) begin
        ext_irq_a_flag_reg <= pin_fall[dtc_pkg::PIN_IRQ_A]                 // [RULE13]
          || (wr_ctl ? reg_wdata[dtc_pkg::CTL_XA_FLAG] : (ext_irq_a_flag_reg && !vec_ext_a)); // [RULE11]
      end else begin
        ext_irq_a_flag_reg <= !pin_level[dtc_pkg::PIN_IRQ_A];              // [RULE13] [RULE11]
      end
      if (trig_b_reg) begin
        ext_irq_b_flag_reg <= pin_fall[dtc_pkg::PIN_IRQ_B]                 // [RULE10] [RULE12]
          || (wr_ctl ? reg_wdata[dtc_pkg::CTL_XB_FLAG] : (ext_irq_b_flag_reg && !vec_ext_b)); // [RULE11]
      end else begin
        ext_irq_b_flag_reg <= !pin_level[dtc_pkg::PIN_IRQ_B];              // [RULE10] [RULE12]
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_reg <= dtc_pkg::RST_DATA;
    end else if (reg_rd) begin
      case (reg_addr)
        dtc_pkg::ADDR_CONTROL: reg_rdata_reg <= {timer_b_overflow_flag_reg, run_b_reg,
                                                 timer_a_overflow_flag_reg, run_a_reg,
                                                 ext_irq_b_flag_reg, trig_b_reg,
                                                 ext_irq_a_flag_reg, trig_a_reg};
        dtc_pkg::ADDR_MODE:    reg_rdata_reg <= mode_reg;
        dtc_pkg::ADDR_A_LOW:   reg_rdata_reg <= timer_a_low_reg;
        dtc_pkg::ADDR_A_HIGH:  reg_rdata_reg <= timer_a_high_reg;
        dtc_pkg::ADDR_B_LOW:   reg_rdata_reg <= timer_b_reg[7:0];
        dtc_pkg::ADDR_B_HIGH:  reg_rdata_reg <= timer_b_reg[15:8];
        default:               reg_rdata_reg <= 8'h00;
      endcase
    end else begin
      reg_rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata             = reg_rdata_reg;
  assign timer_a_overflow_flag = timer_a_overflow_flag_reg;
  assign timer_b_overflow_flag = timer_b_overflow_flag_reg;
  assign ext_irq_a_flag        = ext_irq_a_flag_reg;
  assign ext_irq_b_flag        = ext_irq_b_flag_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_src_clock;
    run_a_reg && !mode_reg[dtc_pkg::MOD_A_SRC] && !mode_reg[dtc_pkg::MOD_A_GATE]
      && (timer_a_mode == dtc_pkg::MODE_WIDE) && !reg_wr
      |=> {timer_a_high_reg, timer_a_low_reg} == 16'($past({timer_a_high_reg, timer_a_low_reg}) + 16'h0001);
  endproperty
  a_src_clock: assert property (p_src_clock) else $error("timer A missed a clock tick"); // [RULE1]
  property p_prescale_carry;
    count_a_en && (timer_a_mode == dtc_pkg::MODE_PRESC) && (timer_a_low_reg[4:0] == 5'h1f) && !reg_wr
      |=> (timer_a_high_reg == 8'($past(timer_a_high_reg) + 8'h01)) && (timer_a_low_reg[4:0] == 5'h00);
  endproperty
  a_prescale_carry: assert property (p_prescale_carry) else $error("prescaler carry wrong"); // [RULE2]
  property p_prescale_ovf;
    count_a_en && (timer_a_mode == dtc_pkg::MODE_PRESC) && (timer_a_low_reg[4:0] == 5'h1f)
      && (timer_a_high_reg == 8'hff) |=> timer_a_overflow_flag_reg ##1 1'b1;
  endproperty
  a_prescale_ovf: assert property (p_prescale_ovf) else $error("13-bit rollover flag missing"); // [RULE16]
  property p_reload;
    count_a_en && (timer_a_mode == dtc_pkg::MODE_RELOAD) && (timer_a_low_reg == 8'hff) && !reg_wr
      |=> (timer_a_low_reg == $past(timer_a_high_reg)) && timer_a_overflow_flag_reg;
  endproperty
  a_reload: assert property (p_reload) else $error("autoreload wrong"); // [RULE4]
  property p_split_high;
    (timer_a_mode == dtc_pkg::MODE_SPLIT) && run_b_reg && !reg_wr
      |=> timer_a_high_reg == 8'($past(timer_a_high_reg) + 8'h01);
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high byte stalled"); // [RULE5]
  property p_b_vector_clear;
    timer_b_overflow_flag_reg && vec_timer_b && !wr_ctl && !ovf_b && !ovf_split_high
      |=> !timer_b_overflow_flag_reg;
  endproperty
  a_b_vector_clear: assert property (p_b_vector_clear) else $error("B flag not cleared on vector"); // [RULE6]
  property p_b_stopped;
    !run_b_reg && !reg_wr |=> $stable(timer_b_reg);
  endproperty
  a_b_stopped: assert property (p_b_stopped) else $error("timer B moved while stopped"); // [RULE7]
  property p_a_set_wins;
    ovf_a && vec_timer_a |=> timer_a_overflow_flag_reg;
  endproperty
  a_a_set_wins: assert property (p_a_set_wins) else $error("A overflow lost to vector"); // [RULE8]
  property p_a_stopped;
    !run_a_reg && (timer_a_mode != dtc_pkg::MODE_SPLIT) && !reg_wr
      |=> $stable(timer_a_low_reg) && $stable(timer_a_high_reg);
  endproperty
  a_a_stopped: assert property (p_a_stopped) else $error("timer A moved while stopped"); // [RULE9]
  property p_gate_hold;
    mode_reg[dtc_pkg::MOD_A_GATE] && !pin_level[dtc_pkg::PIN_IRQ_A] && !reg_wr
      && (timer_a_mode != dtc_pkg::MODE_SPLIT) |=> $stable(timer_a_low_reg);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated timer counted"); // [RULE15]
  property p_edge_b;
    trig_b_reg && pin_fall[dtc_pkg::PIN_IRQ_B] |=> ext_irq_b_flag_reg;
  endproperty
  a_edge_b: assert property (p_edge_b) else $error("ext B edge not flagged"); // [RULE12]
  property p_level_a;
    !trig_a_reg && !pin_level[dtc_pkg::PIN_IRQ_A] && vec_ext_a |=> ext_irq_a_flag_reg;
  endproperty
  a_level_a: assert property (p_level_a) else $error("level flag cleared by vector"); // [RULE11]
  c_reload:  cover property (count_a_en && (timer_a_mode == dtc_pkg::MODE_RELOAD) && (timer_a_low_reg == 8'hff));
  c_split:   cover property (ovf_split_high);
  c_ext_b:   cover property (trig_b_reg && pin_fall[dtc_pkg::PIN_IRQ_B]);
  c_pin_cnt: cover property (count_a_en && mode_reg[dtc_pkg::MOD_A_SRC]);

endmodule

//--- tb_dual_timer_counter_control.sv
`timescale 1ns/1ps
module tb_dual_timer_counter_control;
  logic        clk;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [3:0]  vec;
  wire  [3:0]  flg;
  wire         cnt_pin;
  wire         irq_a;
  wire         irq_b;
  logic [31:0] seed;
  logic [31:0] q;
  logic [7:0]  r;
  int          bad_count;
  int          comparisons;

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  dtc_pin_model u_pins (.clk(clk), .count_pin(cnt_pin), .irq_a(irq_a), .irq_b(irq_b));

  dtc_timer_ctrl u_dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vec_timer_a(vec[0]), .vec_timer_b(vec[1]),
    .vec_ext_a(vec[2]), .vec_ext_b(vec[3]), .timer_a_count_pin(cnt_pin), .ext_irq_a_pin(irq_a),
    .ext_irq_b_pin(irq_b), .timer_a_overflow_flag(flg[0]), .timer_b_overflow_flag(flg[1]),
    .ext_irq_a_flag(flg[2]), .ext_irq_b_flag(flg[3])
  );

  // Seen against expected, counted either way
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Every bus task starts one edge later, so strobes never get two writes in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, want);
  endtask

  // Vector pulse, then the flag one cycle on
  task automatic pulse(input int i, input logic want);
    @(posedge clk);
    vec <= 4'h1 << i;
    @(posedge clk);
    vec <= 4'h0;
    @(negedge clk);
    check({7'h00, flg[i]}, {7'h00, want});
  endtask

  task automatic wait_flag(input int i, input logic want);
    int n;
    n = 0;
    while (flg[i] !== want && n < 12) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, flg[i]}, {7'h00, want});
    if (n == 12) close_out();
  endtask

  // Reference timer: k increments; packs A high, A low, B low, B flag, A flag
  function automatic logic [31:0] model(input int md, input int hi, input int lo, input int k, input bit rb);
    int v;
    int fa;
    int fb;
    fa = 0;
    fb = 0;
    for (int j = 0; j < k; j++) begin
      case (md)
        0: begin
          v = (hi * 32 + lo % 32 + 1) % 8192;
          fa = fa | (v == 0);
          hi = v / 32;
          lo = (lo / 32) * 32 + v % 32;
        end
        1: begin
          v = (hi * 256 + lo + 1) % 65536;
          fa = fa | (v == 0);
          hi = v / 256;
          lo = v % 256;
        end
        2: begin
          fa = fa | (lo == 255);
          lo = (lo == 255) ? hi : lo + 1;
        end
        default: begin
          lo = (lo + 1) % 256;
          fa = fa | (lo == 0);
          if (rb) begin
            hi = (hi + 1) % 256;
            fb = fb | (hi == 0);
          end
        end
      endcase
    end
    return {8'(hi), 8'(lo), 8'(rb ? k : 0), 6'h00, 1'(fb), 1'(fa)};
  endfunction

  // Preload, run for k edges (or k pin falls), stop keeping model flags, compare
  task automatic run_case(input logic [7:0] mreg, input logic [7:0] hi, input logic [7:0] lo, input int k,
                          input logic [7:0] runs, input bit stall);
    logic [31:0] m;
    logic [31:0] e;
    m = model(int'(mreg[1:0]), int'(hi), int'(lo), stall ? 0 : k, runs[6]);
    e = model(int'(mreg[1:0]), int'(hi), int'(lo), stall ? 0 : (mreg[2] ? k : k - 2), runs[6]);
    wr(dtc_pkg::ADDR_MODE, mreg);
    wr(dtc_pkg::ADDR_A_HIGH, hi);
    wr(dtc_pkg::ADDR_A_LOW, lo);
    wr(dtc_pkg::ADDR_B_LOW, 8'h00);
    wr(dtc_pkg::ADDR_B_HIGH, 8'h00);
    wr(dtc_pkg::ADDR_CONTROL, runs);
    if (mreg[2]) begin
      u_pins.falls(k);
      repeat (6) @(posedge clk);
    end else begin
      repeat (k - 2) @(posedge clk);
    end
    // Hardware-set flags looked at before the stop write rewrites them
    @(negedge clk);
    check({6'h00, flg[1:0]}, {6'h00, e[1:0]});
    wr(dtc_pkg::ADDR_CONTROL, {m[1], 1'b0, m[0], 5'h00});
    rd(dtc_pkg::ADDR_A_LOW, m[23:16]);
    rd(dtc_pkg::ADDR_A_HIGH, m[31:24]);
    rd(dtc_pkg::ADDR_B_LOW, m[15:8]);
    rd(dtc_pkg::ADDR_CONTROL, {m[1], 1'b0, m[0], 3'h0, stall, 1'b0});
    if (m[0]) pulse(0, 1'b0);
    if (m[1]) pulse(1, 1'b0);
  endtask

  // Hang guard
  initial begin
    #500000;
    bad_count++;
    close_out();
  end

  initial begin
    nrst      = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    vec       = 4'h0;
    bad_count = 0;
    comparisons = 0;
    seed      = 32'd3628;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, one-cycle read data, unmapped slot
    for (int a = 8'h88; a <= 8'h8e; a++) begin
      rd(8'(a), 8'h00);
    end
    @(negedge clk);
    check(reg_rdata, 8'h00);
    q = xs();
    wr(8'h8e, q[7:0]);
    rd(8'h8e, 8'h00);
    r = q[15:8];
    wr(dtc_pkg::ADDR_MODE, r);
    rd(dtc_pkg::ADDR_MODE, r);
    $display("test registers done");
    // Timer modes, random start and length in the wide mode
    q = xs();
    run_case(8'h01, 8'hff, {5'h1f, q[2:0]}, 2 + int'(q[6:4]), 8'h10, 1'b0);
    run_case(8'h00, 8'hff, 8'hfe, 4, 8'h10, 1'b0);
    run_case(8'h02, 8'h80, 8'hfe, 4, 8'h10, 1'b0);
    run_case(8'h03, 8'hfe, 8'h10, 4, 8'h50, 1'b0);
    run_case(8'h03, 8'hfe, 8'hff, 3, 8'h10, 1'b0);
    run_case(8'h05, 8'h00, 8'h00, 5, 8'h10, 1'b0);
    u_pins.set_irq(0, 1'b0);
    repeat (5) @(posedge clk);
    run_case(8'h09, 8'h00, 8'h40, 6, 8'h10, 1'b1);
    u_pins.set_irq(0, 1'b1);
    repeat (5) @(posedge clk);
    $display("test timers done");
    // Reset with both timers stopped: A low count and control byte read back as zero
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(dtc_pkg::ADDR_A_LOW, 8'h00);
    rd(dtc_pkg::ADDR_CONTROL, 8'h00);
    $display("test reset done");
    // Both interrupt lines, edge then level
    for (int i = 0; i < 2; i++) begin
      wr(dtc_pkg::ADDR_CONTROL, 8'h05);
      u_pins.set_irq(i, 1'b0);
      wait_flag(2 + i, 1'b1);
      rd(dtc_pkg::ADDR_CONTROL, (i == 0) ? 8'h07 : 8'h0d);
      u_pins.set_irq(i, 1'b1);
      repeat (6) @(posedge clk);
      @(negedge clk);
      check({7'h00, flg[2 + i]}, 8'h01);
      pulse(2 + i, 1'b0);
      wr(dtc_pkg::ADDR_CONTROL, 8'h00);
      u_pins.set_irq(i, 1'b0);
      wait_flag(2 + i, 1'b1);
      pulse(2 + i, 1'b1);
      u_pins.set_irq(i, 1'b1);
      wait_flag(2 + i, 1'b0);
    end
    $display("test interrupts done");
    close_out();
  end
endmodule
